// [pkg/dma_ctl_pkg.sv]
// constants for the control-byte decode block
package dma_ctl_pkg;
  // group base byte identification
  localparam logic [7:0] mode_sel_mask = 8'h83;
  localparam logic [7:0] mode_sel_val = 8'h81;
  localparam logic [7:0] eob_sel_mask = 8'hC7;
  localparam logic [7:0] eob_sel_val = 8'h82;
  localparam logic [7:0] match_sel_mask = 8'h83;
  localparam logic [7:0] match_sel_val = 8'h80;
  localparam logic [7:0] cmd_sel_mask = 8'h83;
  localparam logic [7:0] cmd_sel_val = 8'h83;
  // mode group base byte fields
  localparam int mode_lo_pos = 5;
  localparam int mode_port_lo_pos = 2;
  localparam int mode_port_hi_pos = 3;
  localparam int mode_intctl_pos = 4;
  // interrupt control byte fields
  localparam int ic_match_pos = 0;
  localparam int ic_eob_pos = 1;
  localparam int ic_pulse_lo_pos = 2;
  localparam int ic_pulse_ptr_pos = 3;
  localparam int ic_vec_ptr_pos = 4;
  localparam int ic_sav_pos = 5;
  localparam int ic_ready_pos = 6;
  // end-of-block/control group fields
  localparam int eob_restart_pos = 5;
  localparam int eob_wait_pos = 4;
  localparam int eob_rdy_hi_pos = 3;
  // match/enable group fields
  localparam int me_int_en_pos = 5;
  localparam int me_dma_en_pos = 6;
  // commands
  localparam logic [7:0] cmd_reset = 8'hC3;
  localparam logic [7:0] cmd_rst_tim_a = 8'hC7;
  localparam logic [7:0] cmd_rst_tim_b = 8'hCB;
  localparam logic [7:0] cmd_load = 8'hCF;
  localparam logic [7:0] cmd_continue = 8'hD3;
  localparam logic [7:0] cmd_dis_int = 8'hAF;
  localparam logic [7:0] cmd_en_int = 8'hAB;
  localparam logic [7:0] cmd_en_dma = 8'h87;
  // reset values
  localparam logic [7:0] ctl_reset_val = 8'h00;
  localparam logic [1:0] mode_reset_val = 2'h0;
  // pointer values for the mode group followers
  typedef enum logic [5:0]
  {
    ptr_idle = 6'b00_0001,
    ptr_port_lo = 6'b00_0010,
    ptr_port_hi = 6'b00_0100,
    ptr_intctl = 6'b00_1000,
    ptr_pulse = 6'b01_0000,
    ptr_vector = 6'b10_0000
  } ptr_state_t;
endpackage

// [logic/byte_match.sv]
`timescale 1ns/1ps
// compares the pulse offset against the low byte of the byte counter
module byte_match #(
  parameter int W = 8
) (
  // compare operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  // result
  output logic eq_o
);
  initial
  begin
    if (W < 1)
      $error("byte_match width must be positive");
  end
  assign eq_o = (a_i == b_i);
endmodule

// [logic/irq_latch.sv]
`timescale 1ns/1ps
// sticky cause latch: set beats clear
module irq_latch (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // control
  input wire logic set_i,
  input wire logic clr_i,
  // state
  output logic q_o
);
  logic q_r;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q_r <= 1'b0;
    else if (set_i)
      q_r <= 1'b1;
    else if (clr_i)
      q_r <= 1'b0;
  end
  assign q_o = q_r;
endmodule

// [logic/dma_ctl_decode.sv]
// Function
// - mode bits 6:5 pick byte, burst or continuous transfer
// - mode bits 2 and 3 set route next two bytes to port address
// - mode bit 4 points to interrupt control; its bits 4,3 to vector, pulse
// - interrupt control bits 0,1,6 arm match, end-of-block and ready causes
// - causes only arm; raising needs enable command, match-group bit 5 or return opcode
// - armed cause stops and releases the bus before interrupting
// - status-affects-vector puts cause in vector bits 1 and 2
// - pulse byte matched to low count byte pulses interrupt each 256 bytes
// - control bit 5 picks stop or auto restart; restart clears end status
// - control bit 4 muxes the wait pin; wait extends cycles while master
// - control bit 3 sets ready input polarity
// - command byte has bits 7,1,0; all but enable-transfer disable requests
// - reset command clears interrupt, requests, force-ready, restart, wait
// - C7 and CB restore default timing for port one and two
// - load clears count and force-ready, loads source now, destination later
// - continue clears count and keeps both address counters
// - AF drops interrupt line, blocks all but pulse interrupts, keeps latches
// - interrupts come up off; AB or return opcode enables them
// - armed causes latch while disabled and fire once re-enabled
// - 87 enables bus requests gated by ready or force-ready
// - match group bit 5 enables interrupt generation
`timescale 1ns/1ps
module dma_ctl_decode
  import dma_ctl_pkg::*;
#(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // control byte write from the host
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // events from the transfer engine
  input wire logic [CW-1:0] byte_cnt_i,
  input wire logic cnt_step_i,
  input wire logic match_i,
  input wire logic eob_i,
  input wire logic rdy_i,
  input wire logic wait_n_i,
  input wire logic bus_master_i,
  input wire logic force_ready_cmd_i,
  input wire logic dest_first_cnt_i,
  input wire logic dest_fixed_i,
  input wire logic stop_on_match_i,
  input wire logic stop_on_eob_i,
  // interrupt acknowledge and return opcode decode
  input wire logic int_ack_i,
  input wire logic return_from_interrupt_opcode_i,
  // configuration seen by the engine
  output logic [1:0] mode_o,
  output logic [15:0] port_b_addr_o,
  output logic auto_restart_o,
  output logic rdy_active_high_o,
  output logic wait_mux_o,
  output logic timing_a_dflt_o,
  output logic timing_b_dflt_o,
  // counter control pulses
  output logic cnt_clr_o,
  output logic src_load_o,
  output logic dst_load_o,
  output logic eob_status_clr_o,
  // bus request and stall
  output logic bus_req_o,
  output logic stop_o,
  output logic cycle_hold_o,
  // interrupt
  output logic int_n_o,
  output logic [7:0] vector_o
);
  typedef struct packed {
    ptr_state_t ptr;
    logic ic_follow;
    logic [1:0] mode;
    logic [15:0] port_b;
    logic [7:0] intctl;
    logic [7:0] pulse;
    logic [7:0] vector;
    logic restart;
    logic wait_mux;
    logic rdy_hi;
    logic tim_a;
    logic tim_b;
    logic dma_en;
    logic int_en;
    logic force_rdy;
    logic dst_pend;
    logic ip;
    logic under_service_latch;
    logic cnt_clr;
    logic src_load;
    logic dst_load;
    logic eob_clr;
    logic bus_req;
    logic stop;
    logic hold;
    logic int_n;
    logic pulse_int;
    logic [7:0] vec_out;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic hit_match;
  logic hit_eob;
  logic hit_rdy;
  logic pulse_eq;
  logic [1:0] cause_nxt;
  logic [1:0] cause_r;
  logic rdy_act;

  initial
  begin
    if (CW < 8)
      $error("byte counter must be at least 8 bits");
  end

  assign rdy_act = s_r.rdy_hi ? rdy_i : !rdy_i;

  // each armed cause is held until the pending flag ip falls (return opcode or reset command)
  irq_latch u_lat_match (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .set_i(match_i && s_r.intctl[ic_match_pos]
           && (stop_on_match_i || stop_on_eob_i)),
    .clr_i(s_nxt.ip == 1'b0 && s_r.ip),
    .q_o(hit_match)
  );
  irq_latch u_lat_eob (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .set_i(eob_i && s_r.intctl[ic_eob_pos] && stop_on_eob_i),
    .clr_i(s_nxt.ip == 1'b0 && s_r.ip),
    .q_o(hit_eob)
  );
  irq_latch u_lat_rdy (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .set_i(rdy_act && !s_r.bus_req && s_r.dma_en
           && s_r.intctl[ic_ready_pos]),
    .clr_i(s_nxt.ip == 1'b0 && s_r.ip),
    .q_o(hit_rdy)
  );

  byte_match #(
    .W(8)
  ) u_pulse_cmp (
    .a_i(s_r.pulse),
    .b_i(byte_cnt_i[7:0]),
    .eq_o(pulse_eq)
  );

  // cause code placed into vector bits 2:1
  always_comb
  begin
    if (hit_rdy)
      cause_nxt = 2'h0;
    else if (hit_match)
      cause_nxt = 2'h1;
    else
      cause_nxt = 2'h2;
  end
  assign cause_r = cause_nxt;

  always_comb
  begin
    logic any_cause;
    logic is_cmd;
    any_cause = hit_match || hit_eob || hit_rdy;
    is_cmd = (wdata_i & cmd_sel_mask) == cmd_sel_val;
    s_nxt = s_r;
    s_nxt.cnt_clr = 1'b0;
    s_nxt.src_load = 1'b0;
    s_nxt.dst_load = 1'b0;
    s_nxt.eob_clr = 1'b0;
    s_nxt.pulse_int = 1'b0;
    // destination counter loads on its first count unless fixed
    if (s_r.dst_pend && dest_first_cnt_i)
    begin
      s_nxt.dst_pend = 1'b0;
      s_nxt.dst_load = !dest_fixed_i;
    end
    if (!bus_master_i)
      s_nxt.force_rdy = 1'b0;
    if (eob_i)
    begin
      if (s_r.restart)
        s_nxt.eob_clr = 1'b1;
      else
      begin
        s_nxt.dma_en = 1'b0;
        s_nxt.force_rdy = 1'b0;
      end
    end
    if (match_i && stop_on_match_i)
    begin
      s_nxt.dma_en = 1'b0;
      s_nxt.force_rdy = 1'b0;
    end
    if (force_ready_cmd_i)
      s_nxt.force_rdy = 1'b1;
    // armed causes pend; stop the bus first
    if (any_cause && !s_r.ip)
      s_nxt.ip = 1'b1;
    if (s_r.intctl[ic_pulse_lo_pos] && s_r.intctl[ic_pulse_ptr_pos]
        && cnt_step_i && pulse_eq)
      s_nxt.pulse_int = 1'b1;
    if (int_ack_i && s_r.ip && !s_r.int_n)
    begin
      s_nxt.under_service_latch = 1'b1;
      s_nxt.vec_out = s_r.vector;
      if (s_r.intctl[ic_sav_pos])
        s_nxt.vec_out[2:1] = cause_r;
    end
    if (return_from_interrupt_opcode_i && s_r.under_service_latch)
    begin
      s_nxt.under_service_latch = 1'b0;
      s_nxt.ip = 1'b0;
      s_nxt.int_en = 1'b1;
    end
    if (wr_i)
    begin
      // followers take priority over base-byte decode
      case (s_r.ptr)
        ptr_port_lo:
        begin
          s_nxt.port_b[7:0] = wdata_i;
          s_nxt.ptr = ptr_port_hi;
        end
        ptr_port_hi:
        begin
          s_nxt.port_b[15:8] = wdata_i;
          // a base byte that also pointed at interrupt control goes on there
          s_nxt.ptr = s_r.ic_follow ? ptr_intctl : ptr_idle;
        end
        ptr_intctl:
        begin
          s_nxt.intctl = wdata_i;
          if (wdata_i[ic_pulse_ptr_pos])
            s_nxt.ptr = ptr_pulse;
          else if (wdata_i[ic_vec_ptr_pos])
            s_nxt.ptr = ptr_vector;
          else
            s_nxt.ptr = ptr_idle;
        end
        ptr_pulse:
        begin
          s_nxt.pulse = wdata_i;
          s_nxt.ptr = s_r.intctl[ic_vec_ptr_pos] ? ptr_vector : ptr_idle;
        end
        ptr_vector:
        begin
          s_nxt.vector = wdata_i;
          s_nxt.ptr = ptr_idle;
        end
        default:
        begin
          s_nxt.dma_en = 1'b0;
          if ((wdata_i & mode_sel_mask) == mode_sel_val)
          begin
            s_nxt.mode = wdata_i[mode_lo_pos +: 2];
            s_nxt.ic_follow = wdata_i[mode_intctl_pos];
            if (wdata_i[mode_port_lo_pos] && wdata_i[mode_port_hi_pos])
              s_nxt.ptr = ptr_port_lo;
            else if (wdata_i[mode_intctl_pos])
              s_nxt.ptr = ptr_intctl;
          end
          else if ((wdata_i & eob_sel_mask) == eob_sel_val)
          begin
            s_nxt.restart = wdata_i[eob_restart_pos];
            s_nxt.wait_mux = wdata_i[eob_wait_pos];
            s_nxt.rdy_hi = wdata_i[eob_rdy_hi_pos];
          end
          else if ((wdata_i & match_sel_mask) == match_sel_val)
          begin
            if (wdata_i[me_int_en_pos])
              s_nxt.int_en = 1'b1;
            if (wdata_i[me_dma_en_pos])
              s_nxt.dma_en = 1'b1;
          end
          else if (is_cmd)
          begin
            if (wdata_i == cmd_reset)
            begin
              s_nxt.int_en = 1'b0;
              s_nxt.ip = 1'b0;
              s_nxt.under_service_latch = 1'b0;
              s_nxt.force_rdy = 1'b0;
              s_nxt.restart = 1'b0;
              s_nxt.wait_mux = 1'b0;
              s_nxt.tim_a = 1'b1;
              s_nxt.tim_b = 1'b1;
            end
            else if (wdata_i == cmd_rst_tim_a)
              s_nxt.tim_a = 1'b1;
            else if (wdata_i == cmd_rst_tim_b)
              s_nxt.tim_b = 1'b1;
            else if (wdata_i == cmd_load)
            begin
              s_nxt.cnt_clr = 1'b1;
              s_nxt.src_load = 1'b1;
              s_nxt.dst_pend = 1'b1;
              s_nxt.force_rdy = 1'b0;
            end
            else if (wdata_i == cmd_continue)
              s_nxt.cnt_clr = 1'b1;
            else if (wdata_i == cmd_dis_int)
              s_nxt.int_en = 1'b0;
            else if (wdata_i == cmd_en_int)
              s_nxt.int_en = 1'b1;
            else if (wdata_i == cmd_en_dma)
              s_nxt.dma_en = 1'b1;
          end
        end
      endcase
    end
    // stop and release before the interrupt line goes active
    s_nxt.stop = s_nxt.ip && !s_nxt.under_service_latch;
    s_nxt.bus_req = s_nxt.dma_en && !s_nxt.stop && !s_nxt.under_service_latch
                    && (rdy_act || s_nxt.force_rdy);
    s_nxt.hold = s_r.wait_mux && bus_master_i && !wait_n_i;
    s_nxt.int_n = !((s_r.int_en && s_r.ip && !s_r.under_service_latch && !s_r.bus_req
                     && !bus_master_i) || s_r.pulse_int);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r <= '0;
      s_r.ptr <= ptr_idle;
      s_r.mode <= mode_reset_val;
      s_r.intctl <= ctl_reset_val;
      s_r.tim_a <= 1'b1;
      s_r.tim_b <= 1'b1;
      s_r.int_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign mode_o = s_r.mode;
  assign port_b_addr_o = s_r.port_b;
  assign auto_restart_o = s_r.restart;
  assign rdy_active_high_o = s_r.rdy_hi;
  assign wait_mux_o = s_r.wait_mux;
  assign timing_a_dflt_o = s_r.tim_a;
  assign timing_b_dflt_o = s_r.tim_b;
  assign cnt_clr_o = s_r.cnt_clr;
  assign src_load_o = s_r.src_load;
  assign dst_load_o = s_r.dst_load;
  assign eob_status_clr_o = s_r.eob_clr;
  assign bus_req_o = s_r.bus_req;
  assign stop_o = s_r.stop;
  assign cycle_hold_o = s_r.hold;
  assign int_n_o = s_r.int_n;
  assign vector_o = s_r.vec_out;

  property p_cmd_disables;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (wr_i && s_r.ptr == ptr_idle && wdata_i != cmd_en_dma
     && (wdata_i & match_sel_mask) != match_sel_val) |=> !bus_req_o;
  endproperty
  a_cmd_disables: assert property (p_cmd_disables)
    else $error("control byte left bus request on");

  property p_load_pulses;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (wr_i && s_r.ptr == ptr_idle && wdata_i == cmd_load)
    |=> cnt_clr_o && src_load_o && !s_r.force_rdy;
  endproperty
  a_load_pulses: assert property (p_load_pulses)
    else $error("load did not clear count and load source");

  property p_int_needs_en;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (!int_n_o && !$past(s_r.pulse_int)) |-> $past(s_r.int_en);
  endproperty
  a_int_needs_en: assert property (p_int_needs_en)
    else $error("interrupt raised while disabled");

  property p_int_after_release;
    @(posedge core_clk_i) disable iff (!rstn_i)
    $fell(int_n_o) && !$past(s_r.pulse_int) |-> $past(!bus_req_o);
  endproperty
  a_int_after_release: assert property (p_int_after_release)
    else $error("interrupt asserted while requesting bus");

  property p_dis_int;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (wr_i && s_r.ptr == ptr_idle && wdata_i == cmd_dis_int)
    |=> !s_r.int_en ##0 (s_r.ip == $past(s_r.ip));
  endproperty
  a_dis_int: assert property (p_dis_int)
    else $error("disable interrupts changed latches");

  sequence s_mode_port;
    wr_i && s_r.ptr == ptr_idle && (wdata_i & mode_sel_mask) == mode_sel_val
    && wdata_i[mode_port_lo_pos] && wdata_i[mode_port_hi_pos];
  endsequence
  property p_mode_port;
    @(posedge core_clk_i) disable iff (!rstn_i)
    s_mode_port |=> s_r.ptr == ptr_port_lo;
  endproperty
  a_mode_port: assert property (p_mode_port)
    else $error("port address pointer not set");

  property p_reset_cmd;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (wr_i && s_r.ptr == ptr_idle && wdata_i == cmd_reset)
    |=> !s_r.int_en && !s_r.ip && timing_a_dflt_o && timing_b_dflt_o
        && !auto_restart_o && !wait_mux_o;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command incomplete");

  property p_continue;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (wr_i && s_r.ptr == ptr_idle && wdata_i == cmd_continue)
    |=> cnt_clr_o && !src_load_o;
  endproperty
  a_continue: assert property (p_continue)
    else $error("continue loaded address counters");
endmodule

// [dv/host_model.sv]
// host side model that writes control bytes into the decode block
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic core_clk_i,
  // control byte write
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    @(posedge core_clk_i);
    wr_o <= 1'b1;
    wdata_o <= b;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    // an idle bus does not keep showing the last byte
    wdata_o <= ~b;
  endtask
  // a pending follower pointer may swallow up to three of these
  task automatic abort();
    repeat (6) send(8'hC3);
  endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the control byte decode block
`timescale 1ns/1ps
module tb;
  import dma_ctl_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wr;
  logic [7:0] wdata;
  logic [15:0] byte_cnt = 16'h0000;
  logic [4:0] evt = 5'h00;
  logic rdy = 1'b0;
  logic wait_n = 1'b1;
  logic bus_master = 1'b0;
  logic dest_fixed = 1'b0;
  logic stop_on_eob = 1'b0;
  logic [1:0] mode;
  logic [15:0] port_b_addr;
  logic auto_restart, rdy_hi, wait_mux, tim_a, tim_b;
  logic cnt_clr, src_load, dst_load, eob_clr;
  logic bus_req, stop, cycle_hold, int_n;
  logic [7:0] vector;
  logic [3:0] mon;
  int failures = 0;
  int cmp_count = 0;
  int n_clr = 0;
  int n_src = 0;
  int n_dst = 0;
  int n_eclr = 0;

  always #10 core_clk = ~core_clk;
  assign mon = {cycle_hold, stop, bus_req, int_n};

  host_model host_model_inst (
    .core_clk_i(core_clk),
    .wr_o(wr),
    .wdata_o(wdata)
  );

  dma_ctl_decode dma_ctl_decode_inst (
    .core_clk_i(core_clk), .rstn_i(rstn), .wr_i(wr), .wdata_i(wdata),
    .byte_cnt_i(byte_cnt), .cnt_step_i(evt[1]), .match_i(1'b0),
    .eob_i(evt[0]), .rdy_i(rdy), .wait_n_i(wait_n),
    .bus_master_i(bus_master), .force_ready_cmd_i(1'b0),
    .dest_first_cnt_i(evt[2]), .dest_fixed_i(dest_fixed),
    .stop_on_match_i(1'b0), .stop_on_eob_i(stop_on_eob),
    .int_ack_i(evt[3]), .return_from_interrupt_opcode_i(evt[4]), .mode_o(mode),
    .port_b_addr_o(port_b_addr), .auto_restart_o(auto_restart),
    .rdy_active_high_o(rdy_hi), .wait_mux_o(wait_mux),
    .timing_a_dflt_o(tim_a), .timing_b_dflt_o(tim_b),
    .cnt_clr_o(cnt_clr), .src_load_o(src_load), .dst_load_o(dst_load),
    .eob_status_clr_o(eob_clr), .bus_req_o(bus_req), .stop_o(stop),
    .cycle_hold_o(cycle_hold), .int_n_o(int_n), .vector_o(vector)
  );

  // pulse outputs are counted so no single cycle is missed
  always @(posedge core_clk)
  begin
    if (cnt_clr === 1'b1) n_clr++;
    if (src_load === 1'b1) n_src++;
    if (dst_load === 1'b1) n_dst++;
    if (eob_clr === 1'b1) n_eclr++;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // hold=1: level must stay for n cycles; hold=0: level must come within n
  task automatic wait_sig(input int k, input logic lvl, input int n,
                          input bit hold, input string m);
    int i;
    cmp_count++;
    for (i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      #1;
      if (hold && mon[k] !== lvl) break;
      if (!hold && mon[k] === lvl) return;
    end
    if (hold && i == n) return;
    failures++;
    $display("BAD %0t %s", $time, m);
    conclude();
  endtask

  task automatic ev(input int k);
    @(posedge core_clk);
    evt[k] <= 1'b1;
    @(posedge core_clk);
    evt <= 5'h00;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic send(input logic [7:0] b);
    host_model_inst.send(b);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk({tim_a, tim_b}, 16'h0003, "timing after reset");
    chk(int_n, 16'h0001, "int after reset");
    for (int m = 0; m < 3; m++)
    begin
      send({1'b1, m[1:0], 5'b0_0001});
      settle();
      chk(mode, m[15:0], "mode");
    end
    send(8'h9D);
    host_model_inst.abort();
    send(8'hB1);
    send(8'h00);
    settle();
    chk(mode, 16'h0001, "mode after abort");
    send(8'h8D);
    send(8'h34);
    send(8'h12);
    settle();
    chk(port_b_addr, 16'h1234, "port address");
    send(8'hBA);
    settle();
    chk({auto_restart, wait_mux, rdy_hi}, 16'h0007, "eob group");
    @(posedge core_clk);
    bus_master <= 1'b1;
    wait_n <= 1'b0;
    wait_sig(3, 1'b1, 5, 1'b0, "no cycle hold");
    @(posedge core_clk);
    wait_n <= 1'b1;
    wait_sig(3, 1'b0, 5, 1'b0, "cycle hold stuck");
    @(posedge core_clk);
    bus_master <= 1'b0;
    n_eclr = 0;
    ev(0);
    settle();
    chk(n_eclr[15:0], 16'h0001, "restart status clear");
    send(8'hC3);
    settle();
    chk({auto_restart, wait_mux}, 16'h0000, "reset command");
    send(8'h8A);
    rdy <= 1'b1;
    send(8'h87);
    wait_sig(1, 1'b1, 10, 1'b0, "no bus request");
    send(8'hAF);
    wait_sig(1, 1'b0, 10, 1'b0, "request kept");
    send(8'h82);
    send(8'h87);
    wait_sig(1, 1'b0, 8, 1'b1, "request on idle ready");
    @(posedge core_clk);
    rdy <= 1'b0;
    wait_sig(1, 1'b1, 10, 1'b0, "low ready ignored");
    send(8'h83);
    wait_sig(1, 1'b0, 10, 1'b0, "disable ignored");
    {n_clr, n_src, n_dst} = '0;
    send(8'hCF);
    settle();
    chk({n_clr[7:0], n_src[7:0]}, 16'h0101, "load pulses");
    chk(n_dst[15:0], 16'h0000, "early dest load");
    ev(2);
    settle();
    chk(n_dst[15:0], 16'h0001, "dest load");
    send(8'hCF);
    dest_fixed <= 1'b1;
    ev(2);
    settle();
    chk(n_dst[15:0], 16'h0001, "fixed dest loaded");
    send(8'hD3);
    settle();
    chk({n_clr[7:0], n_src[7:0]}, 16'h0302, "continue pulses");
    send(8'h91);
    send(8'h32);
    send(8'hA0);
    @(posedge core_clk);
    stop_on_eob <= 1'b1;
    ev(0);
    wait_sig(2, 1'b1, 10, 1'b0, "no stop");
    wait_sig(0, 1'b1, 5, 1'b1, "int while disabled");
    send(8'hAB);
    wait_sig(0, 1'b0, 10, 1'b0, "no int");
    send(8'hAF);
    wait_sig(0, 1'b1, 10, 1'b0, "int line not released");
    send(8'hAB);
    wait_sig(0, 1'b0, 10, 1'b0, "pending int lost");
    ev(3);
    settle();
    chk(vector, 16'h00A4, "vector");
    send(8'hAF);
    wait_sig(0, 1'b1, 10, 1'b0, "int kept");
    ev(4);
    ev(0);
    wait_sig(0, 1'b0, 10, 1'b0, "no int after return");
    @(posedge core_clk);
    stop_on_eob <= 1'b0;
    send(8'hC3);
    send(8'h91);
    send(8'h0C);
    send(8'h05);
    send(8'hA0);
    @(posedge core_clk);
    byte_cnt <= 16'h0305;
    ev(1);
    wait_sig(0, 1'b0, 10, 1'b0, "no pulse");
    wait_sig(0, 1'b1, 10, 1'b0, "pulse stuck");
    @(posedge core_clk);
    byte_cnt <= 16'h0306;
    ev(1);
    wait_sig(0, 1'b1, 8, 1'b1, "pulse off offset");
    send(8'hC7);
    send(8'hCB);
    settle();
    chk({tim_a, tim_b}, 16'h0003, "timing");
    conclude();
  end
endmodule
